// File: logic/rgb_status_pkg.sv
// Constants shared by the threshold, status and result register block.
// Assumes an I2C byte engine outside that turns bus transfers into register strobes.
// What this block does
// RULE_01 - Thresholds are 16 bits, low byte first
// RULE_02 - Result at or below lower raises alert
// RULE_03 - Lower thresholds reset zero, upper reset ones
// RULE_04 - Persistency up to eight integration cycles
// RULE_05 - Status bit 0 shows window alert
// RULE_06 - Alert holds until status read completes
// RULE_07 - Status bit 1 shows conversion done
// RULE_08 - Brownout flag resets high, status 0x04
// RULE_09 - Host writing zero clears brownout flag
// RULE_10 - Status bits 5:4 show converting colour
// RULE_11 - Results mapped green, red, blue, low first
// RULE_12 - Twelve-bit results occupy bits 0 to 11
// RULE_13 - Results refreshed every conversion end
// RULE_14 - Results double buffered for whole reads
// RULE_15 - Result bytes read zero after power-on
// RULE_16 - Channel select picks compared colour
// RULE_17 - Persistency field needs 1,2,4,8 hits
// RULE_18 - At or above upper also out of window
package rgb_status_pkg;
  // ****************************************************************
  // Register offsets
  // ****************************************************************
  localparam logic [7:0] ADDR_LOWER_LSB = 8'h04;
  localparam logic [7:0] ADDR_LOWER_MSB = 8'h05;
  localparam logic [7:0] ADDR_UPPER_LSB = 8'h06;
  localparam logic [7:0] ADDR_UPPER_MSB = 8'h07;
  localparam logic [7:0] ADDR_STATUS = 8'h08;
  localparam logic [7:0] ADDR_GREEN_LSB = 8'h09;
  localparam logic [7:0] ADDR_GREEN_MSB = 8'h0A;
  localparam logic [7:0] ADDR_RED_LSB = 8'h0B;
  localparam logic [7:0] ADDR_RED_MSB = 8'h0C;
  localparam logic [7:0] ADDR_BLUE_LSB = 8'h0D;
  localparam logic [7:0] ADDR_BLUE_MSB = 8'h0E;

  // ****************************************************************
  // Reset values
  // ****************************************************************
  localparam logic [7:0] RST_LOWER_BYTE = 8'h00;
  localparam logic [7:0] RST_UPPER_BYTE = 8'hFF;
  localparam logic [7:0] RST_STATUS = 8'h04;
  localparam logic [15:0] RST_RESULT = 16'h0000;

  // ****************************************************************
  // Status field positions
  // ****************************************************************
  localparam int STAT_ALERT_BIT = 0;
  localparam int STAT_DONE_BIT = 1;
  localparam int STAT_BROWNOUT_BIT = 2;
  localparam int STAT_CHAN_LSB = 4;
  localparam int STAT_CHAN_MSB = 5;

  // ****************************************************************
  // Channel codes and persistency
  // ****************************************************************
  localparam logic [1:0] CHAN_NONE = 2'h0;
  localparam logic [1:0] CHAN_GREEN = 2'h1;
  localparam logic [1:0] CHAN_RED = 2'h2;
  localparam logic [1:0] CHAN_BLUE = 2'h3;
  localparam int NUM_COLOURS = 3;
  // Results above this width are cut in twelve-bit mode
  localparam logic [15:0] MASK_12BIT = 16'h0FFF;
  // Counter wide enough for the largest hit count of eight
  localparam int PERSIST_CNT_W = 4;
endpackage : rgb_status_pkg

// File: logic/persist_filter.sv
// Persistency filter: counts consecutive out-of-window conversions.
// Assumes one sample strobe per conversion of the selected colour.
`timescale 1ns/10ps
module persist_filter
  import rgb_status_pkg::*;
(
  // Clock and reset
  input wire logic ref_clk_i,
  input wire logic nrst_i,
  // Sample from the window comparator
  input wire logic sample_i,
  input wire logic outside_i,
  input wire logic [1:0] persist_count_i,
  // Alert request
  output logic fire_o
);
  // ****************************************************************
  // Hit counter
  // ****************************************************************
  logic [PERSIST_CNT_W-1:0] hits_reg; // Consecutive outside samples so far
  logic [PERSIST_CNT_W-1:0] hits_next;
  logic [PERSIST_CNT_W-1:0] needed; // 1, 2, 4 or 8
  logic [PERSIST_CNT_W-1:0] hits_inc;
  logic reached;

  // Code n asks for two to the n hits
  assign needed = PERSIST_CNT_W'(1) << persist_count_i; // see RULE_17
  assign hits_inc = hits_reg + PERSIST_CNT_W'(1);
  assign reached = sample_i && outside_i && (hits_inc >= needed); // see RULE_04
  // An in-window sample breaks the run; a fire restarts it
  assign hits_next = !sample_i ? hits_reg :
                     (!outside_i || reached) ? '0 : hits_inc;
  // Combinational pulse in the cycle of the qualifying sample
  assign fire_o = reached;

  // Counter register
  always_ff @(posedge ref_clk_i or negedge nrst_i) begin
    if (!nrst_i) begin
      hits_reg <= '0;
    end else begin
      hits_reg <= hits_next;
    end
  end
endmodule : persist_filter

// File: logic/result_buffer.sv
// One colour's result word with its read-side snapshot.
// Assumes the host reads the low byte before the high byte.
`timescale 1ns/10ps
module result_buffer
  import rgb_status_pkg::*;
(
  // Clock and reset
  input wire logic ref_clk_i,
  input wire logic nrst_i,
  // Converter side
  input wire logic load_i,
  input wire logic [15:0] result_i,
  // Host side
  input wire logic lsb_read_i,
  output logic [15:0] word_o,
  output logic [7:0] msb_hold_o
);
  // ****************************************************************
  // Live word and high-byte snapshot
  // ****************************************************************
  logic [15:0] word_reg; // Whole result, replaced in one edge
  logic [7:0] hold_reg; // High byte frozen at the low-byte read

  // Live result, refreshed at each conversion end
  always_ff @(posedge ref_clk_i or negedge nrst_i) begin
    if (!nrst_i) begin
      word_reg <= RST_RESULT; // see RULE_15
    end else if (load_i) begin
      word_reg <= result_i; // see RULE_13
    end
  end

  // Snapshot so a new conversion between the two byte reads cannot tear the word
  always_ff @(posedge ref_clk_i or negedge nrst_i) begin
    if (!nrst_i) begin
      hold_reg <= RST_RESULT[15:8];
    end else if (lsb_read_i) begin
      hold_reg <= word_reg[15:8]; // see RULE_14
    end
  end

  assign word_o = word_reg;
  assign msb_hold_o = hold_reg;
endmodule : result_buffer

// File: logic/rgb_status_regs.sv
// Threshold, status and colour result registers of the light sensor.
// Assumes an I2C byte engine presents each register byte as one-cycle strobes,
// and that the converter core reports conversions with one-cycle strobes.
`timescale 1ns/10ps
module rgb_status_regs
  import rgb_status_pkg::*;
(
  // Clock and reset
  input wire logic ref_clk_i,
  input wire logic nrst_i,
  // Register port from the I2C byte engine
  input wire logic [7:0] reg_addr_i,
  input wire logic reg_wr_i,
  input wire logic [7:0] reg_wdata_i,
  input wire logic reg_rd_i,
  input wire logic reg_rd_done_i,
  output logic [7:0] reg_rdata_o,
  // Configuration from the configuration registers
  input wire logic [1:0] alert_channel_select_i,
  input wire logic [1:0] persist_count_i,
  input wire logic resolution_12bit_i,
  // Converter core
  input wire logic [1:0] conv_channel_i,
  input wire logic conv_start_i,
  input wire logic conv_done_i,
  input wire logic [1:0] conv_done_channel_i,
  input wire logic [15:0] conv_result_i,
  input wire logic brownout_event_i,
  // Alert pin and flag
  output logic alert_n_o,
  output logic window_alert_flag_o
);
  // ****************************************************************
  // Threshold registers
  // ****************************************************************
  logic [7:0] lower_lsb_reg; // Lower threshold, low byte
  logic [7:0] lower_msb_reg; // Lower threshold, high byte
  logic [7:0] upper_lsb_reg; // Upper threshold, low byte
  logic [7:0] upper_msb_reg; // Upper threshold, high byte
  logic [15:0] threshold_byte_lower; // Assembled lower threshold
  logic [15:0] threshold_byte_upper; // Assembled upper threshold

  // Write decode, one strobe per byte
  logic wr_lower_lsb;
  logic wr_lower_msb;
  logic wr_upper_lsb;
  logic wr_upper_msb;
  logic wr_status;

  assign wr_lower_lsb = reg_wr_i && (reg_addr_i == ADDR_LOWER_LSB);
  assign wr_lower_msb = reg_wr_i && (reg_addr_i == ADDR_LOWER_MSB);
  assign wr_upper_lsb = reg_wr_i && (reg_addr_i == ADDR_UPPER_LSB);
  assign wr_upper_msb = reg_wr_i && (reg_addr_i == ADDR_UPPER_MSB);
  assign wr_status = reg_wr_i && (reg_addr_i == ADDR_STATUS);

  // Low byte at the lower address, high byte at the next one
  assign threshold_byte_lower = {lower_msb_reg, lower_lsb_reg}; // see RULE_01
  assign threshold_byte_upper = {upper_msb_reg, upper_lsb_reg}; // see RULE_01

  // Lower threshold bytes; reset leaves the window wide open
  always_ff @(posedge ref_clk_i or negedge nrst_i) begin
    if (!nrst_i) begin
      lower_lsb_reg <= RST_LOWER_BYTE; // see RULE_03
      lower_msb_reg <= RST_LOWER_BYTE; // see RULE_03
    end else begin
      if (wr_lower_lsb) lower_lsb_reg <= reg_wdata_i;
      if (wr_lower_msb) lower_msb_reg <= reg_wdata_i;
    end
  end

  // Upper threshold bytes
  always_ff @(posedge ref_clk_i or negedge nrst_i) begin
    if (!nrst_i) begin
      upper_lsb_reg <= RST_UPPER_BYTE; // see RULE_03
      upper_msb_reg <= RST_UPPER_BYTE; // see RULE_03
    end else begin
      if (wr_upper_lsb) upper_lsb_reg <= reg_wdata_i;
      if (wr_upper_msb) upper_msb_reg <= reg_wdata_i;
    end
  end

  // ****************************************************************
  // Result capture
  // ****************************************************************
  // Twelve-bit mode clears the top nibble so stale bits never show
  logic [15:0] ambient_light_result;
  assign ambient_light_result = resolution_12bit_i ? (conv_result_i & MASK_12BIT)
                                                   : conv_result_i; // see RULE_12

  // Per-colour words, index 0 green, 1 red, 2 blue
  logic [15:0] colour_word [NUM_COLOURS];
  logic [7:0] colour_hold [NUM_COLOURS];
  logic [NUM_COLOURS-1:0] colour_load;
  logic [NUM_COLOURS-1:0] colour_lsb_read;

  genvar gi;
  generate
    for (gi = 0; gi < NUM_COLOURS; gi++) begin : g_colour
      // Channel code is index plus one; low byte at twice the index past green
      localparam logic [1:0] CODE = 2'(gi + 1);
      localparam logic [7:0] LSB_ADDR = 8'(ADDR_GREEN_LSB + 2 * gi);

      assign colour_load[gi] = conv_done_i && (conv_done_channel_i == CODE); // see RULE_13
      assign colour_lsb_read[gi] = reg_rd_i && (reg_addr_i == LSB_ADDR); // see RULE_11

      result_buffer u_result (
        .ref_clk_i(ref_clk_i),
        .nrst_i(nrst_i),
        .load_i(colour_load[gi]),
        .result_i(ambient_light_result),
        .lsb_read_i(colour_lsb_read[gi]),
        .word_o(colour_word[gi]),
        .msb_hold_o(colour_hold[gi])
      );
    end
  endgenerate

  // ****************************************************************
  // Window comparison
  // ****************************************************************
  // Pick the selected colour's fresh result; code none never samples
  logic selected_sample;
  logic below_or_equal;
  logic above_or_equal;
  logic outside_window;
  logic alert_fire;

  assign selected_sample = conv_done_i && (alert_channel_select_i != CHAN_NONE) &&
                           (conv_done_channel_i == alert_channel_select_i); // see RULE_16
  assign below_or_equal = ambient_light_result <= threshold_byte_lower; // see RULE_02
  assign above_or_equal = ambient_light_result >= threshold_byte_upper; // see RULE_18
  assign outside_window = below_or_equal || above_or_equal;

  // Consecutive-hit filter ahead of the alert flag
  persist_filter u_persist (
    .ref_clk_i(ref_clk_i),
    .nrst_i(nrst_i),
    .sample_i(selected_sample),
    .outside_i(outside_window),
    .persist_count_i(persist_count_i),
    .fire_o(alert_fire)
  );

  // ****************************************************************
  // Status flags
  // ****************************************************************
  logic window_alert_flag; // Bit 0, sticky
  logic conversion_done_flag; // Bit 1
  logic brownout_flag; // Bit 2, set at power-up
  logic [1:0] channel_in_conversion; // Bits 5:4
  logic status_read_done; // Eight-bit status transfer finished
  logic status_rd;
  logic brownout_clear;

  assign status_rd = reg_rd_i && (reg_addr_i == ADDR_STATUS);
  assign status_read_done = reg_rd_done_i && (reg_addr_i == ADDR_STATUS); // see RULE_06
  // Only a zero in the brownout position clears; other bits of the write are ignored
  assign brownout_clear = wr_status && !reg_wdata_i[STAT_BROWNOUT_BIT]; // see RULE_09

  // Alert flag: a new alert in the clearing cycle survives the clear
  always_ff @(posedge ref_clk_i or negedge nrst_i) begin
    if (!nrst_i) begin
      window_alert_flag <= RST_STATUS[STAT_ALERT_BIT];
    end else if (alert_fire) begin
      window_alert_flag <= 1'b1; // see RULE_02
    end else if (status_read_done) begin
      window_alert_flag <= 1'b0; // see RULE_06
    end
  end

  // Conversion done: set when a conversion ends, cleared by a start or a finished status read
  always_ff @(posedge ref_clk_i or negedge nrst_i) begin
    if (!nrst_i) begin
      conversion_done_flag <= RST_STATUS[STAT_DONE_BIT];
    end else if (conv_done_i) begin
      conversion_done_flag <= 1'b1; // see RULE_07
    end else if (conv_start_i || status_read_done) begin
      conversion_done_flag <= 1'b0; // see RULE_07
    end
  end

  // Brownout: reset value is one, a new brownout beats a host clear
  always_ff @(posedge ref_clk_i or negedge nrst_i) begin
    if (!nrst_i) begin
      brownout_flag <= RST_STATUS[STAT_BROWNOUT_BIT]; // see RULE_08
    end else if (brownout_event_i) begin
      brownout_flag <= 1'b1; // see RULE_08
    end else if (brownout_clear) begin
      brownout_flag <= 1'b0; // see RULE_09
    end
  end

  // Colour now in conversion, followed one cycle late
  always_ff @(posedge ref_clk_i or negedge nrst_i) begin
    if (!nrst_i) begin
      channel_in_conversion <= RST_STATUS[STAT_CHAN_MSB:STAT_CHAN_LSB];
    end else begin
      channel_in_conversion <= conv_channel_i; // see RULE_10
    end
  end

  // Assembled status byte; reserved bits read zero
  logic [7:0] status_byte;
  always_comb begin
    status_byte = 8'h00;
    status_byte[STAT_ALERT_BIT] = window_alert_flag; // see RULE_05
    status_byte[STAT_DONE_BIT] = conversion_done_flag; // see RULE_07
    status_byte[STAT_BROWNOUT_BIT] = brownout_flag; // see RULE_08
    status_byte[STAT_CHAN_MSB:STAT_CHAN_LSB] = channel_in_conversion; // see RULE_10
  end

  // ****************************************************************
  // Read data
  // ****************************************************************
  // Threshold bytes and result low bytes come live; result high bytes come from the snapshot taken at the low read
  logic [7:0] rdata_next;
  logic [7:0] rdata_reg;

  always_comb begin
    unique case (reg_addr_i)
      ADDR_LOWER_LSB: rdata_next = lower_lsb_reg;
      ADDR_LOWER_MSB: rdata_next = lower_msb_reg;
      ADDR_UPPER_LSB: rdata_next = upper_lsb_reg;
      ADDR_UPPER_MSB: rdata_next = upper_msb_reg;
      ADDR_STATUS: rdata_next = status_byte;
      ADDR_GREEN_LSB: rdata_next = colour_word[0][7:0]; // see RULE_11
      ADDR_GREEN_MSB: rdata_next = colour_hold[0]; // see RULE_14
      ADDR_RED_LSB: rdata_next = colour_word[1][7:0]; // see RULE_11
      ADDR_RED_MSB: rdata_next = colour_hold[1]; // see RULE_14
      ADDR_BLUE_LSB: rdata_next = colour_word[2][7:0]; // see RULE_11
      ADDR_BLUE_MSB: rdata_next = colour_hold[2]; // see RULE_14
      // Unmapped addresses read zero
      default: rdata_next = 8'h00;
    endcase
  end

  // Read byte is captured at the read strobe and held for the whole transfer
  always_ff @(posedge ref_clk_i or negedge nrst_i) begin
    if (!nrst_i) begin
      rdata_reg <= 8'h00;
    end else if (reg_rd_i) begin
      rdata_reg <= rdata_next;
    end
  end

  // ****************************************************************
  // Outputs
  // ****************************************************************
  assign reg_rdata_o = rdata_reg;
  // Pin is the inverse of the sticky flag, so both clear together
  assign alert_n_o = !window_alert_flag; // see RULE_02
  assign window_alert_flag_o = window_alert_flag; // see RULE_05

  // status_rd marks the capture of the status byte; the clear waits for the
  // transfer's end, so an alert raised between the capture and that end is cleared unseen
  logic unused_status_rd;
  assign unused_status_rd = status_rd;
endmodule : rgb_status_regs

// File: verification/rgb_status_regs_props.sv
// Checker for the threshold, status and result register block.
// Sees only the top ports; attached by the bind below the module.
`timescale 1ns/10ps
module rgb_status_regs_props
  import rgb_status_pkg::*;
(
  // Clock and reset
  input wire logic ref_clk_i,
  input wire logic nrst_i,
  // Register port
  input wire logic [7:0] reg_addr_i,
  input wire logic reg_rd_i,
  input wire logic reg_rd_done_i,
  input wire logic [7:0] reg_rdata_o,
  // Configuration and converter
  input wire logic [1:0] alert_channel_select_i,
  input wire logic [1:0] persist_count_i,
  input wire logic resolution_12bit_i,
  input wire logic conv_done_i,
  input wire logic [1:0] conv_done_channel_i,
  input wire logic [15:0] conv_result_i,
  // Alert outputs
  input wire logic alert_n_o,
  input wire logic window_alert_flag_o
);
  default clocking @(posedge ref_clk_i); endclocking
  default disable iff (!nrst_i);
  // End of a status byte transfer, the only clearing cause
  wire stat_done = reg_rd_done_i && (reg_addr_i == ADDR_STATUS);
  // Selected colour done with a hit count of one
  wire sel_hit = conv_done_i && (persist_count_i == 2'h0)
    && (alert_channel_select_i != CHAN_NONE) && (conv_done_channel_i == alert_channel_select_i);

  property p_pin; alert_n_o == !window_alert_flag_o; endproperty
  a_pin: assert property (p_pin)
    else $error("alert pin disagrees with flag");
  property p_clear; stat_done && !conv_done_i |=> !window_alert_flag_o && alert_n_o; endproperty
  a_clear: assert property (p_clear)
    else $error("alert not cleared by status read");
  property p_hold; window_alert_flag_o && !stat_done |=> window_alert_flag_o; endproperty
  a_hold: assert property (p_hold)
    else $error("alert dropped without status read");
  property p_cause; $rose(window_alert_flag_o) |-> $past(conv_done_i); endproperty
  a_cause: assert property (p_cause)
    else $error("alert rose without conversion");
  property p_none;
    conv_done_i && alert_channel_select_i == CHAN_NONE && !window_alert_flag_o
      |=> !window_alert_flag_o;
  endproperty
  a_none: assert property (p_none)
    else $error("alert with no channel selected");
  property p_low; sel_hit && conv_result_i == 16'h0000 |=> window_alert_flag_o; endproperty
  a_low: assert property (p_low)
    else $error("zero result did not alert");
  property p_high;
    sel_hit && !resolution_12bit_i && conv_result_i == 16'hFFFF |=> window_alert_flag_o;
  endproperty
  a_high: assert property (p_high)
    else $error("full-scale result did not alert");
  property p_unmapped; reg_rd_i && reg_addr_i == 8'h0F |=> reg_rdata_o == 8'h00; endproperty
  a_unmapped: assert property (p_unmapped)
    else $error("unmapped read not zero");
  property p_status;
    reg_rd_i && reg_addr_i == ADDR_STATUS
      |=> reg_rdata_o[0] == $past(window_alert_flag_o) && reg_rdata_o[7:6] == 2'h0;
  endproperty
  a_status: assert property (p_status)
    else $error("status bit 0 not the alert flag");
  property p_stand; !reg_rd_i |=> $stable(reg_rdata_o); endproperty
  a_stand: assert property (p_stand)
    else $error("read data moved without a read");
  c_fire: cover property ($rose(window_alert_flag_o));
  c_clear: cover property (stat_done && window_alert_flag_o);
  c_eight: cover property (persist_count_i == 2'h3 ##1 $rose(window_alert_flag_o));
endmodule : rgb_status_regs_props

bind rgb_status_regs rgb_status_regs_props chk (.ref_clk_i(ref_clk_i), .nrst_i(nrst_i),
  .reg_addr_i(reg_addr_i), .reg_rd_i(reg_rd_i), .reg_rd_done_i(reg_rd_done_i),
  .reg_rdata_o(reg_rdata_o), .alert_channel_select_i(alert_channel_select_i),
  .persist_count_i(persist_count_i), .resolution_12bit_i(resolution_12bit_i),
  .conv_done_i(conv_done_i), .conv_done_channel_i(conv_done_channel_i),
  .conv_result_i(conv_result_i), .alert_n_o(alert_n_o),
  .window_alert_flag_o(window_alert_flag_o));

// File: verification/i2c_host_model.sv
// Host side model: turns byte accesses into register strobes.
// Assumes the block samples strobes on the rising clock edge.
`timescale 1ns/10ps
module i2c_host_model (
  // Clock
  input wire logic ref_clk_i,
  // Strobes toward the block
  output logic [7:0] reg_addr_o,
  output logic reg_wr_o,
  output logic [7:0] reg_wdata_o,
  output logic reg_rd_o,
  output logic reg_rd_done_o,
  // Read data back
  input wire logic [7:0] reg_rdata_i
);
  initial begin
    reg_addr_o = 8'h00;
    reg_wr_o = 1'b0;
    reg_wdata_o = 8'h00;
    reg_rd_o = 1'b0;
    reg_rd_done_o = 1'b0;
  end
  // Write one byte; data is not held after, so show its inverse
  task automatic wr(input logic [7:0] a, input logic [7:0] dat);
    @(posedge ref_clk_i);
    reg_addr_o <= a;
    reg_wdata_o <= dat;
    reg_wr_o <= 1'b1;
    @(posedge ref_clk_i);
    reg_wr_o <= 1'b0;
    reg_wdata_o <= ~dat;
  endtask : wr
  // Read one byte; address held until the byte transfer ends
  task automatic rd(input logic [7:0] a, output logic [7:0] dat);
    @(posedge ref_clk_i);
    reg_addr_o <= a;
    reg_rd_o <= 1'b1;
    @(posedge ref_clk_i);
    reg_rd_o <= 1'b0;
    @(negedge ref_clk_i);
    dat = reg_rdata_i;
    @(posedge ref_clk_i);
    reg_rd_done_o <= 1'b1;
    @(posedge ref_clk_i);
    reg_rd_done_o <= 1'b0;
  endtask : rd
endmodule : i2c_host_model

// File: verification/rgb_status_regs_tb.sv
// Self-checking bench for the threshold, status and result registers.
// Host strobes come from the host model; converter strobes from here.
`timescale 1ns/10ps
module rgb_status_regs_tb
  import rgb_status_pkg::*;
;
  // ****************************************************************
  // Stimulus and observed signals
  // ****************************************************************
  logic ref_clk_i = 1'b0;
  logic nrst_i = 1'b0;
  logic [1:0] sel = 2'h0;
  logic [1:0] persist = 2'h0;
  logic res12 = 1'b0;
  logic [1:0] conv_ch = 2'h0;
  logic conv_start = 1'b0;
  logic conv_done = 1'b0;
  logic [1:0] done_ch = 2'h0;
  logic [15:0] result = 16'h0000;
  logic brownout = 1'b0;
  logic [7:0] addr, wdata, rdata, d;
  logic wr, rd, rd_done, alert_n, flag;
  int fails = 0;
  int n_tests = 0;
  int cyc = 0;
  // Pin and flag packed together: alerted reads 01, idle reads 10
  localparam logic [7:0] ALERTED = 8'h01;
  localparam logic [7:0] IDLE = 8'h02;
  // Register rows: address, byte written, byte read back
  typedef struct packed { logic [7:0] a; logic [7:0] w; logic [7:0] e; } row_t;
  row_t rows [8] = '{'{8'h04, 8'h00, 8'h00}, '{8'h05, 8'h01, 8'h01}, '{8'h06, 8'h00, 8'h00},
    '{8'h07, 8'hF0, 8'hF0}, '{8'h08, 8'hFB, 8'h00}, '{8'h09, 8'h55, 8'h00},
    '{8'h0E, 8'hAA, 8'h00}, '{8'h0F, 8'h77, 8'h00}};
  // Full scale, upper boundary, just inside
  logic [15:0] up_v [3] = '{16'hFFFF, 16'hF000, 16'hEFFF};

  initial forever #10 ref_clk_i = ~ref_clk_i;

  i2c_host_model host (.ref_clk_i(ref_clk_i), .reg_addr_o(addr), .reg_wr_o(wr),
    .reg_wdata_o(wdata), .reg_rd_o(rd), .reg_rd_done_o(rd_done), .reg_rdata_i(rdata));

  rgb_status_regs dut (.ref_clk_i(ref_clk_i), .nrst_i(nrst_i), .reg_addr_i(addr),
    .reg_wr_i(wr), .reg_wdata_i(wdata), .reg_rd_i(rd), .reg_rd_done_i(rd_done),
    .reg_rdata_o(rdata), .alert_channel_select_i(sel), .persist_count_i(persist),
    .resolution_12bit_i(res12), .conv_channel_i(conv_ch), .conv_start_i(conv_start),
    .conv_done_i(conv_done), .conv_done_channel_i(done_ch), .conv_result_i(result),
    .brownout_event_i(brownout), .alert_n_o(alert_n), .window_alert_flag_o(flag));

  task automatic chk(input logic [7:0] seen, input logic [7:0] exp);
    n_tests++;
    if (seen !== exp) begin
      fails++;
      $display("MISMATCH at %0t: saw %h expected %h", $time, seen, exp);
    end
  endtask : chk
  // One finished conversion; the result bus shows garbage afterwards
  task automatic conv(input logic [1:0] ch, input logic [15:0] v);
    @(posedge ref_clk_i);
    conv_done <= 1'b1;
    done_ch <= ch;
    result <= v;
    @(posedge ref_clk_i);
    conv_done <= 1'b0;
    result <= ~v;
  endtask : conv
  // Pin and flag, once the last edge has landed
  task automatic look(input logic [7:0] exp);
    @(negedge ref_clk_i);
    chk({6'h00, alert_n, flag}, exp);
  endtask : look
  task automatic give_verdict;
    $display("Comparisons %0d, mismatches %0d", n_tests, fails);
    if (fails == 0 && n_tests > 0) begin
      $display("All checks passed");
    end else begin
      $display("Checks failed");
    end
    $finish;
  endtask : give_verdict

  // Hang guard, far above the few hundred cycles the run needs
  always @(posedge ref_clk_i) begin
    cyc++;
    if (cyc == 20000) begin
      fails++;
      give_verdict();
    end
  end

  initial begin
    repeat (8) @(posedge ref_clk_i);
    nrst_i <= 1'b1;
    for (int a = 4; a < 15; a++) begin
      host.rd(8'(a), d);
      chk(d, (a == 6 || a == 7) ? 8'hFF : (a == 8) ? RST_STATUS : 8'h00);
    end
    foreach (rows[i]) begin
      host.wr(rows[i].a, rows[i].w);
      host.rd(rows[i].a, d);
      chk(d, rows[i].e);
    end
    // Twelve-bit mode cuts the stored word
    res12 <= 1'b1;
    conv(CHAN_RED, 16'hFFFF);
    host.rd(ADDR_RED_LSB, d);
    chk(d, 8'hFF);
    host.rd(ADDR_RED_MSB, d);
    chk(d, 8'h0F);
    res12 <= 1'b0;
    // High byte read returns the word seen at the low byte read
    for (int c = 1; c < 4; c++) begin
      conv(2'(c), 16'(16'h2345 * c));
      host.rd(8'(7 + 2 * c), d);
      chk(d, 8'(16'h2345 * c));
      conv(2'(c), 16'h0000);
      host.rd(8'(8 + 2 * c), d);
      chk(d, 8'((16'h2345 * c) >> 8));
      host.rd(8'(7 + 2 * c), d);
      chk(d, 8'h00);
    end
    // Lower threshold is 0x0100, upper 0xF000
    conv(CHAN_GREEN, 16'h0000);
    sel <= CHAN_GREEN;
    look(IDLE);
    conv(CHAN_RED, 16'h0000);
    look(IDLE);
    conv(CHAN_GREEN, 16'h0101);
    look(IDLE);
    conv(CHAN_GREEN, 16'h0100);
    look(ALERTED);
    conv(CHAN_GREEN, 16'h0800);
    look(ALERTED);
    host.rd(ADDR_STATUS, d);
    chk(d, 8'h03);
    look(IDLE);
    foreach (up_v[k]) begin
      conv(CHAN_GREEN, up_v[k]);
      look(k < 2 ? ALERTED : IDLE);
      host.rd(ADDR_STATUS, d);
    end
    // Hit counts 1, 2, 4, 8; an in-window sample restarts the count
    for (int p = 0; p < 4; p++) begin
      persist <= 2'(p);
      repeat ((1 << p) - 1) conv(CHAN_GREEN, 16'h0000);
      conv(CHAN_GREEN, 16'h0800);
      repeat ((1 << p) - 1) conv(CHAN_GREEN, 16'h0000);
      look(IDLE);
      conv(CHAN_GREEN, 16'h0000);
      look(ALERTED);
      host.rd(ADDR_STATUS, d);
    end
    for (int c = 0; c < 4; c++) begin
      conv_ch <= 2'(c);
      host.rd(ADDR_STATUS, d);
      chk(d, {2'h0, 2'(c), 4'h0});
    end
    // Start clears done; brownout sets until written to zero
    conv_ch <= CHAN_NONE;
    conv(CHAN_BLUE, 16'h0800);
    conv_start <= 1'b1;
    brownout <= 1'b1;
    @(posedge ref_clk_i);
    conv_start <= 1'b0;
    brownout <= 1'b0;
    host.rd(ADDR_STATUS, d);
    chk(d, 8'h04);
    conv(CHAN_BLUE, 16'h0800);
    host.rd(ADDR_STATUS, d);
    chk(d, 8'h06);
    host.wr(ADDR_STATUS, 8'h00);
    host.rd(ADDR_STATUS, d);
    chk(d, 8'h00);
    // Reset in mid-run with the alert up
    persist <= 2'h0;
    conv(CHAN_GREEN, 16'h0000);
    nrst_i <= 1'b0;
    repeat (2) @(posedge ref_clk_i);
    nrst_i <= 1'b1;
    look(IDLE);
    host.rd(ADDR_STATUS, d);
    chk(d, RST_STATUS);
    host.rd(ADDR_GREEN_LSB, d);
    chk(d, 8'h00);
    give_verdict();
  end
endmodule : rgb_status_regs_tb
